// ===== src/sap_consts.svh
// sap_consts: numeric constants for the serial audio port pin block
// assumes: included by bare name from every file that needs a figure
`ifndef SAP_CONSTS_SVH
`define SAP_CONSTS_SVH

`define SAP_WORD_BITS 24
`define SAP_CHANNELS 3
`define SAP_FIFO_W (`SAP_WORD_BITS * `SAP_CHANNELS)
`define SAP_FIFO_DEPTH 16
`define SAP_PADS 5
`define SAP_PAD_RCLK 0
`define SAP_PAD_TCLK 1
`define SAP_PAD_DATA0 2
`define SAP_PAD_FS 5
`define SAP_SYNC_W 6
`define SAP_IDX_W 5
`define SAP_CLK_PERIOD_NS 10
`define SAP_BCLK_HALF_NS 60
`define SAP_BCLK_HALF_CYC (`SAP_BCLK_HALF_NS / `SAP_CLK_PERIOD_NS)
`define SAP_DIV_W 3

`endif

// ===== src/sap_pkg.sv
// sap_pkg: types shared by the serial audio port pin block
// assumes: sap_consts.svh is on the include path
`default_nettype none
`include "sap_consts.svh"

package sap_pkg;
    typedef logic [`SAP_FIFO_W-1:0] sap_frame_t;
    typedef logic [`SAP_IDX_W-1:0] sap_bit_idx_t;
    typedef enum logic [2:0] {
        SAP_DISC,
        SAP_GPIO_IN,
        SAP_GPIO_OUT,
        SAP_PORT_IN,
        SAP_PORT_OUT
    } sap_pin_mode_e;
endpackage

`default_nettype wire

// ===== src/sap_stream_if.sv
// sap_stream_if: valid/ready word carrier between the pin block and its fifo
// assumes: one source and one sink on the same clock
`default_nettype none

interface sap_stream_if #(
    parameter int W = 8
) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// ===== src/sap_fifo.sv
// sap_fifo: flip-flop fifo, registered ready and valid flags
// assumes: depth is a power of two so the pointers wrap by themselves
`default_nettype none
`include "sap_consts.svh"

module sap_fifo #(
    parameter int W = `SAP_FIFO_W,
    parameter int D = `SAP_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    sap_stream_if.snk wr,
    sap_stream_if.src rd
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW + 1)'(D);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic ready_q;
    logic valid_q;
    logic push;
    logic pop;

    assign push = wr.valid && ready_q;
    assign pop = rd.ready && valid_q;
    assign wr.ready = ready_q;
    assign rd.valid = valid_q;
    assign rd.data = mem_q[rptr_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // flags are registered from the next count so both ports see flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            ready_q <= 1'b0;
            valid_q <= 1'b0;
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != FULL);
            valid_q <= (cnt_d != '0);
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wptr_q] <= wr.data;
        end
    end
endmodule

`default_nettype wire

// ===== src/sap_pins.sv
// sap_pins: clock, flag and data pad routing of the serial audio port
// assumes: pads and frame sync are asynchronous; controls come from logic on ref_clk_i
`default_nettype none
`include "sap_consts.svh"

module sap_pins (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic sync_mode_select_i,
    input wire logic network_mode_i,
    input wire logic receive_clock_direction_i,
    input wire logic transmit_clock_direction_i,
    input wire logic [`SAP_CHANNELS-1:0] data_tx_sel_i,
    input wire logic [`SAP_PADS-1:0] port_sel_i,
    input wire logic [`SAP_PADS-1:0] gpio_conn_i,
    input wire logic [`SAP_PADS-1:0] gpio_dir_i,
    input wire logic [`SAP_PADS-1:0] gpio_out_i,
    output logic [`SAP_PADS-1:0] gpio_in_o,
    input wire logic output_flag_zero_i,
    output logic input_flag_zero_o,
    input wire logic frame_sync_i,
    input wire logic [`SAP_PADS-1:0] pad_i,
    output logic [`SAP_PADS-1:0] pad_o,
    output logic [`SAP_PADS-1:0] pad_oe_o,
    input wire sap_pkg::sap_frame_t tx_frame_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output sap_pkg::sap_frame_t rx_frame_o,
    output logic rx_valid_o,
    output logic tx_underrun_o
);
    import sap_pkg::*;

    localparam int W = `SAP_WORD_BITS;
    localparam sap_bit_idx_t LAST = sap_bit_idx_t'(`SAP_WORD_BITS - 1);

    // ****************************************
    // decode helpers
    // ****************************************

    function automatic sap_pin_mode_e pin_mode(input logic port, input logic conn,
                                               input logic gdir, input logic pdir);
        if (port) begin
            pin_mode = pdir ? SAP_PORT_OUT : SAP_PORT_IN;
        end else if (!conn) begin
            pin_mode = SAP_DISC;
        end else begin
            pin_mode = gdir ? SAP_GPIO_OUT : SAP_GPIO_IN;
        end
    endfunction

    function automatic logic is_port(input sap_pin_mode_e m);
        is_port = (m == SAP_PORT_IN) || (m == SAP_PORT_OUT);
    endfunction

    // a frame sync restarts the slot count at bit zero
    function automatic sap_bit_idx_t next_idx(input sap_bit_idx_t cur, input logic start);
        if (start || cur == LAST) begin
            next_idx = '0;
        end else begin
            next_idx = cur + 1'b1;
        end
    endfunction

    // ****************************************
    // pad synchronisers
    // ****************************************

    logic [`SAP_SYNC_W-1:0] meta_q;
    logic [`SAP_SYNC_W-1:0] sync_q;
    logic [`SAP_PADS-1:0] pad_s;
    logic fs_s;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {frame_sync_i, pad_i};
            sync_q <= meta_q;
        end
    end

    assign pad_s = sync_q[`SAP_PADS-1:0];
    assign fs_s = sync_q[`SAP_PAD_FS];

    // ****************************************
    // per-pad function
    // ****************************************

    sap_pin_mode_e pmode [`SAP_PADS];
    logic [`SAP_PADS-1:0] pdir;

    assign pdir = {data_tx_sel_i, transmit_clock_direction_i, receive_clock_direction_i};

    always_comb begin
        for (int k = 0; k < `SAP_PADS; k++) begin
            pmode[k] = pin_mode(port_sel_i[k], gpio_conn_i[k], gpio_dir_i[k], pdir[k]);
        end
    end

    // ****************************************
    // bit clock generation and selection
    // ****************************************

    logic [`SAP_DIV_W-1:0] div_q;
    logic gclk_q;

    // the generated clock only runs as fast as the core allows: 120 ns period
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
            gclk_q <= 1'b0;
        end else if (div_q == `SAP_DIV_W'(`SAP_BCLK_HALF_CYC - 1)) begin
            div_q <= '0;
            gclk_q <= ~gclk_q;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    logic tclk;
    logic rclk;
    logic tx_act;
    logic rx_act;

    assign tclk = (pmode[`SAP_PAD_TCLK] == SAP_PORT_OUT) ? gclk_q : pad_s[`SAP_PAD_TCLK];
    assign tx_act = is_port(pmode[`SAP_PAD_TCLK]);

    assign rclk = sync_mode_select_i ? tclk :
                  ((pmode[`SAP_PAD_RCLK] == SAP_PORT_OUT) ? gclk_q : pad_s[`SAP_PAD_RCLK]);
    assign rx_act = sync_mode_select_i ? tx_act : is_port(pmode[`SAP_PAD_RCLK]);

    logic tclk_q;
    logic rclk_q;
    logic t_rise;
    logic r_rise;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tclk_q <= 1'b0;
            rclk_q <= 1'b0;
        end else begin
            tclk_q <= tclk;
            rclk_q <= rclk;
        end
    end

    assign t_rise = tx_act && tclk && !tclk_q;
    assign r_rise = rx_act && rclk && !rclk_q;

    // ****************************************
    // frame and slot tracking
    // ****************************************

    logic tfs_q;
    logic rfs_q;
    sap_bit_idx_t tidx_q;
    sap_bit_idx_t ridx_q;
    logic t_start;
    logic r_start;
    sap_bit_idx_t tidx_d;
    sap_bit_idx_t ridx_d;
    logic t_slot;

    assign t_start = fs_s && !tfs_q;
    assign r_start = fs_s && !rfs_q;
    assign tidx_d = next_idx(tidx_q, t_start);
    assign ridx_d = next_idx(ridx_q, r_start);
    assign t_slot = t_rise && (tidx_d == '0);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tfs_q <= 1'b0;
            tidx_q <= '0;
        end else if (t_rise) begin
            tfs_q <= fs_s;
            tidx_q <= tidx_d;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rfs_q <= 1'b0;
            ridx_q <= '0;
        end else if (r_rise) begin
            rfs_q <= fs_s;
            ridx_q <= ridx_d;
        end
    end

    // ****************************************
    // transmit path
    // ****************************************

    sap_stream_if #(.W(`SAP_FIFO_W)) tx_w ();
    sap_stream_if #(.W(`SAP_FIFO_W)) tx_r ();

    assign tx_w.data = tx_frame_i;
    assign tx_w.valid = tx_valid_i;
    assign tx_ready_o = tx_w.ready;
    // the fifo drains only at slot starts, so a stopped bit clock stalls the source
    assign tx_r.ready = t_slot;

    sap_fifo #(.W(`SAP_FIFO_W), .D(`SAP_FIFO_DEPTH)) u_tx_fifo (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr(tx_w),
        .rd(tx_r)
    );

    sap_frame_t tsh_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tsh_q <= '0;
            tx_underrun_o <= 1'b0;
        end else begin
            tx_underrun_o <= t_slot && !tx_r.valid;
            if (t_slot) begin
                tsh_q <= tx_r.valid ? tx_r.data : '0;
            end else if (t_rise) begin
                for (int k = 0; k < `SAP_CHANNELS; k++) begin
                    tsh_q[k*W +: W] <= {tsh_q[k*W +: W-1], 1'b0};
                end
            end
        end
    end

    // ****************************************
    // receive path
    // ****************************************

    sap_frame_t rsh_q;
    sap_frame_t rsh_d;
    logic [`SAP_CHANNELS-1:0] rx_bit;

    always_comb begin
        rsh_d = rsh_q;
        for (int k = 0; k < `SAP_CHANNELS; k++) begin
            rx_bit[k] = (pmode[`SAP_PAD_DATA0 + k] == SAP_PORT_IN) ? pad_s[`SAP_PAD_DATA0 + k] : 1'b0;
            rsh_d[k*W +: W] = {rsh_q[k*W +: W-1], rx_bit[k]};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsh_q <= '0;
            rx_frame_o <= '0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (r_rise) begin
                rsh_q <= rsh_d;
                if (ridx_d == LAST) begin
                    rx_frame_o <= rsh_d;
                    rx_valid_o <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // serial flag zero
    // ****************************************

    logic align;
    logic flag_q;

    assign align = t_rise && (network_mode_i ? (tidx_d == '0) : t_start);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (align && sync_mode_select_i && pmode[`SAP_PAD_RCLK] == SAP_PORT_OUT) begin
            flag_q <= output_flag_zero_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            input_flag_zero_o <= 1'b0;
        end else if (align && sync_mode_select_i && pmode[`SAP_PAD_RCLK] == SAP_PORT_IN) begin
            input_flag_zero_o <= pad_s[`SAP_PAD_RCLK];
        end
    end

    // ****************************************
    // pad drivers
    // ****************************************

    logic [`SAP_PADS-1:0] port_val;

    always_comb begin
        port_val[`SAP_PAD_RCLK] = sync_mode_select_i ? flag_q : gclk_q;
        port_val[`SAP_PAD_TCLK] = gclk_q;
        for (int k = 0; k < `SAP_CHANNELS; k++) begin
            port_val[`SAP_PAD_DATA0 + k] = tsh_q[k*W + W - 1];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pad_o <= '0;
            pad_oe_o <= '0;
            gpio_in_o <= '0;
        end else begin
            for (int k = 0; k < `SAP_PADS; k++) begin
                pad_o[k] <= 1'b0;
                pad_oe_o[k] <= 1'b0;
                gpio_in_o[k] <= 1'b0;
                unique case (pmode[k])
                    SAP_DISC: begin
                    end
                    SAP_GPIO_IN: begin
                        gpio_in_o[k] <= pad_s[k];
                    end
                    SAP_GPIO_OUT: begin
                        pad_oe_o[k] <= 1'b1;
                        pad_o[k] <= gpio_out_i[k];
                    end
                    SAP_PORT_IN: begin
                    end
                    SAP_PORT_OUT: begin
                        pad_oe_o[k] <= 1'b1;
                        pad_o[k] <= port_val[k];
                    end
                endcase
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_flag_out;
        align && sync_mode_select_i && pmode[`SAP_PAD_RCLK] == SAP_PORT_OUT;
    endsequence

    sequence s_flag_in;
        align && sync_mode_select_i && pmode[`SAP_PAD_RCLK] == SAP_PORT_IN;
    endsequence

    property p_rx_clk_async;
        (!sync_mode_select_i && pmode[`SAP_PAD_RCLK] == SAP_PORT_OUT)
            |=> pad_oe_o[`SAP_PAD_RCLK] && pad_o[`SAP_PAD_RCLK] == $past(gclk_q);
    endproperty
    a_rx_clk_async: assert property (p_rx_clk_async) else $error("receive clock pad wrong");

    property p_flag_pin;
        (sync_mode_select_i && pmode[`SAP_PAD_RCLK] == SAP_PORT_OUT)
            |=> pad_oe_o[`SAP_PAD_RCLK] && pad_o[`SAP_PAD_RCLK] == $past(flag_q);
    endproperty
    a_flag_pin: assert property (p_flag_pin) else $error("flag pad not driven by flag");

    property p_flag_dir;
        (sync_mode_select_i && port_sel_i[`SAP_PAD_RCLK] && !receive_clock_direction_i)
            |=> !pad_oe_o[`SAP_PAD_RCLK];
    endproperty
    a_flag_dir: assert property (p_flag_dir) else $error("input flag pad driven");

    property p_flag_out;
        s_flag_out |=> flag_q == $past(output_flag_zero_i);
    endproperty
    a_flag_out: assert property (p_flag_out) else $error("output flag not taken");

    property p_flag_in;
        s_flag_in |=> input_flag_zero_o == $past(pad_s[`SAP_PAD_RCLK]);
    endproperty
    a_flag_in: assert property (p_flag_in) else $error("input flag not captured");

    property p_shared_clk;
        sync_mode_select_i |-> (rclk == tclk) && (rx_act == tx_act);
    endproperty
    a_shared_clk: assert property (p_shared_clk) else $error("receivers not on transmit clock");

    property p_tx_clk;
        (pmode[`SAP_PAD_TCLK] == SAP_PORT_OUT)
            |=> pad_oe_o[`SAP_PAD_TCLK] && pad_o[`SAP_PAD_TCLK] == $past(gclk_q);
    endproperty
    a_tx_clk: assert property (p_tx_clk) else $error("transmit clock pad wrong");

    property p_reset_disc;
        $past(rst_i) |-> pad_oe_o == '0 && gpio_in_o == '0;
    endproperty
    a_reset_disc: assert property (p_reset_disc) else $error("pad driven after reset");

    property p_flag_hold;
        !align |=> $stable(flag_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved between points");

    for (genvar g = 0; g < `SAP_PADS; g++) begin : g_pad_chk
        property p_gpio_out;
            (pmode[g] == SAP_GPIO_OUT) |=> pad_oe_o[g] && pad_o[g] == $past(gpio_out_i[g]);
        endproperty
        a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong");
        property p_gpio_off;
            (pmode[g] == SAP_DISC) |=> !pad_oe_o[g] && !gpio_in_o[g];
        endproperty
        a_gpio_off: assert property (p_gpio_off) else $error("disconnected pad active");
    end

    for (genvar g = 0; g < `SAP_CHANNELS; g++) begin : g_data_chk
        property p_data_tx;
            (pmode[`SAP_PAD_DATA0 + g] == SAP_PORT_OUT)
                |=> pad_o[`SAP_PAD_DATA0 + g] == $past(tsh_q[g*W + W - 1]);
        endproperty
        a_data_tx: assert property (p_data_tx) else $error("data pad not from shifter");
        property p_data_rx;
            r_rise |=> rsh_q[g*W] == $past(rx_bit[g]);
        endproperty
        a_data_rx: assert property (p_data_rx) else $error("receive shifter missed bit");
    end
endmodule

`default_nettype wire

// ===== bench/sap_codec_model.sv
// sap_codec_model: far-side codec that makes bit clock, frame sync and data
// assumes: the bench resolves the pads; clock stands still low between runs
`default_nettype none

module sap_codec_model (
    input wire logic [4:0] pad_i,
    input wire logic run_i,
    input wire logic sync_i,
    input wire logic flag_i,
    output logic [4:0] ext_o,
    output logic fs_o,
    output logic [71:0] cap_o,
    output logic [71:0] done_o,
    output int ncap_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic bclk = 1'b0;
    logic [2:0] sd = 3'h0;
    logic [71:0] cur = 72'h0;
    logic [23:0] sh [3];
    int idx = 0;
    int frames = 0;

    // sync mode turns pad 0 into a flag; idle data lines sit at the pull-down level
    assign ext_o = {sd, bclk, sync_i ? flag_i : bclk};

    initial begin
        fs_o = 1'b0;
        cap_o = 72'h0;
        done_o = 72'h0;
        ncap_o = 0;
    end

    // a run only stops at a frame boundary, so the last rise the device sees has frame sync low
    always begin
        if (!run_i && idx == 0) begin
            idx = 0;
            frames = 0;
            bclk = 1'b0;
            sd = 3'h0;
            fs_o = 1'b0;
            wait (run_i);
        end
        if (idx == 0) begin
            cur = 72'({$urandom, $urandom, $urandom});
        end
        fs_o = (idx == 0);
        for (int k = 0; k < 3; k++) begin
            sd[k] = cur[24*k + 23 - idx];
        end
        #62.5 bclk = 1'b1;
        // a word is whole only once its last bit lands at the next frame start
        for (int k = 0; k < 3; k++) begin
            sh[k] = {sh[k][22:0], pad_i[2+k]};
        end
        if (idx == 0) begin
            if (frames > 0) begin
                cap_o = {sh[2], sh[1], sh[0]};
                ncap_o++;
            end
            frames++;
        end
        if (idx == 23) begin
            done_o = cur;
        end
        idx = (idx == 23) ? 0 : idx + 1;
        #62.5 bclk = 1'b0;
    end
endmodule

`default_nettype wire

// ===== bench/tb.sv
// tb: self-checking bench for sap_pins with a codec model on the pads
// assumes: design and model compiled first; fixed seed gives a repeatable run
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sap_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sync_sel = 1'b0;
    logic net_mode = 1'b0;
    logic rcv_dir = 1'b0;
    logic tx_dir = 1'b0;
    logic [2:0] tx_sel = 3'h0;
    logic [4:0] port_sel = 5'h00, g_conn = 5'h00, g_dir = 5'h00, g_out = 5'h00, tb_ext = 5'h00;
    logic out_flag = 1'b0;
    logic flag_drv = 1'b0;
    logic run = 1'b0;
    logic gp_mode = 1'b1;
    logic chk_rx = 1'b0;
    logic tx_valid = 1'b0;
    sap_frame_t tx_frame = 72'h0;
    sap_frame_t rx_frame;
    logic [4:0] gpio_in, pad_o, pad_oe, m_ext, pad_w;
    logic in_flag, tx_ready, rx_valid, tx_underrun, fs;
    logic [71:0] cap, done;
    int ncap;
    int miscompares = 0;
    int num_checks = 0;
    int n_under = 0;
    int n_rise0 = 0;
    int n_rise1 = 0;
    logic [4:0] pad_prev;
    sap_frame_t txq[$];

    // a pad the device does not drive shows the far side's level
    assign pad_w = (pad_oe & pad_o) | (~pad_oe & (gp_mode ? tb_ext : m_ext));

    always #5 ref_clk = ~ref_clk;

    sap_pins DUT (.ref_clk_i(ref_clk), .rst_i(rst), .sync_mode_select_i(sync_sel), .network_mode_i(net_mode),
        .receive_clock_direction_i(rcv_dir), .transmit_clock_direction_i(tx_dir), .data_tx_sel_i(tx_sel),
        .port_sel_i(port_sel), .gpio_conn_i(g_conn), .gpio_dir_i(g_dir), .gpio_out_i(g_out),
        .gpio_in_o(gpio_in), .output_flag_zero_i(out_flag), .input_flag_zero_o(in_flag),
        .frame_sync_i(fs), .pad_i(pad_w), .pad_o(pad_o), .pad_oe_o(pad_oe), .tx_frame_i(tx_frame),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_frame_o(rx_frame), .rx_valid_o(rx_valid),
        .tx_underrun_o(tx_underrun));

    sap_codec_model codec (.pad_i(pad_w), .run_i(run), .sync_i(sync_sel), .flag_i(flag_drv),
        .ext_o(m_ext), .fs_o(fs), .cap_o(cap), .done_o(done), .ncap_o(ncap));

    // ************************************************************
    // checking helpers
    // ************************************************************
    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [71:0] keep(input logic [71:0] w, input logic [2:0] m);
        logic [71:0] r;
        for (int k = 0; k < 3; k++) r[24*k +: 24] = m[k] ? w[24*k +: 24] : 24'h000000;
        return r;
    endfunction

    // bounded by the watchdog below
    task automatic wait_cap(input int n);
        int target;
        target = ncap + n;
        wait (ncap >= target);
        @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        if (chk_rx && rx_valid === 1'b1) begin
            check(rx_frame, keep(done, ~tx_sel));
        end
    end

    // underrun pulses are counted per streaming pass
    always @(posedge ref_clk) begin
        if (tx_underrun === 1'b1) begin
            n_under++;
        end
    end

    // ************************************************************
    // streaming pass: fill fifo while the codec stalls, then drain
    // ************************************************************
    task automatic stream_pass(input logic s);
        sap_frame_t w;
        sync_sel <= s;
        net_mode <= s;
        port_sel <= 5'h1f;
        tx_sel <= s ? 3'($urandom) : 3'h2;
        gp_mode <= 1'b0;
        txq.delete();
        n_under = 0;
        repeat (20) begin
            w = sap_frame_t'({$urandom, $urandom, $urandom});
            tx_valid <= 1'b1;
            tx_frame <= w;
            @(posedge ref_clk);
            if (tx_ready === 1'b1) txq.push_back(w);
        end
        tx_valid <= 1'b0;
        @(posedge ref_clk);
        check(72'(txq.size()), 72'd16);
        check(72'(tx_ready), 72'h0);
        chk_rx <= 1'b1;
        run <= 1'b1;
        // the last two frames find the fifo empty and send zeros
        for (int i = 0; i < 18; i++) begin
            wait_cap(1);
            w = (i < 16) ? txq[i] : 72'h0;
            check(keep(cap, tx_sel), keep(w, tx_sel));
        end
        run <= 1'b0;
        chk_rx <= 1'b0;
        // the codec finishes its frame first: up to 24 bit clocks of about 12.5 core cycles
        repeat (320) @(posedge ref_clk);
        // two empty frames plus the slot begun as the codec is told to stop
        check(72'(n_under), 72'd3);
    endtask

    initial begin
        void'($urandom(4));
        repeat (4) @(posedge ref_clk);
        check(72'(pad_oe), 72'h0);
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(72'(pad_oe), 72'h0);
        for (int i = 0; i < 8; i++) begin
            g_conn <= 5'($urandom);
            g_dir <= 5'($urandom);
            g_out <= 5'($urandom);
            tb_ext <= 5'($urandom);
            repeat (5) @(posedge ref_clk);
            check(72'(pad_oe), 72'(g_conn & g_dir));
            check(72'(pad_o & pad_oe), 72'(g_conn & g_dir & g_out));
            check(72'(gpio_in), 72'(g_conn & ~g_dir & tb_ext));
        end
        stream_pass(1'b0);
        stream_pass(1'b1);
        // flag changes are placed mid-frame so they must wait for the next frame start
        net_mode <= 1'b0;
        run <= 1'b1;
        wait_cap(2);
        repeat (10) @(posedge ref_clk);
        flag_drv <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(72'(in_flag), 72'h0);
        check(72'(pad_oe[0]), 72'h0);
        wait_cap(1);
        repeat (6) @(posedge ref_clk);
        check(72'(in_flag), 72'h1);
        net_mode <= 1'b1;
        rcv_dir <= 1'b1;
        wait_cap(2);
        check(72'({pad_oe[0], pad_o[0]}), 72'h2);
        repeat (10) @(posedge ref_clk);
        out_flag <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(72'(pad_o[0]), 72'h0);
        wait_cap(1);
        repeat (6) @(posedge ref_clk);
        check(72'(pad_o[0]), 72'h1);
        run <= 1'b0;
        // both clock pads drive the generated bit clock in async mode
        sync_sel <= 1'b0;
        tx_dir <= 1'b1;
        port_sel <= 5'h03;
        g_conn <= 5'h00;
        repeat (2) @(posedge ref_clk);
        check(72'(pad_oe), 72'h03);
        // a 120 ns clock rises exactly twice in any 24 core cycles
        for (int i = 0; i < 24; i++) begin
            pad_prev = pad_o;
            @(posedge ref_clk);
            n_rise0 += int'(pad_o[0] && !pad_prev[0]);
            n_rise1 += int'(pad_o[1] && !pad_prev[1]);
        end
        check(72'(n_rise0), 72'd2);
        check(72'(n_rise1), 72'd2);
        finish_test();
    end

    initial begin
        #400_000;
        miscompares++;
        finish_test();
    end
endmodule

`default_nettype wire
